// ==== common/spipc_pkg.sv ====
`default_nettype none
package spipc_pkg;
   // master sequencer states
   typedef enum logic [1:0] {
      SPIPC_IDLE,
      SPIPC_XFER,
      SPIPC_GAP
   } spipc_state_t;
endpackage : spipc_pkg
`default_nettype wire

// ==== common/spipc_regs.svh ====
`ifndef SPIPC_REGS_SVH
`define SPIPC_REGS_SVH

// register byte offsets
`define SPIPC_CTRL_OFF  8'h00
`define SPIPC_STAT_OFF  8'h04
`define SPIPC_DIV_OFF   8'h08
`define SPIPC_TX_OFF    8'h0C
`define SPIPC_RX_OFF    8'h10

// control field positions
`define SPIPC_EN    0
`define SPIPC_MST   1
`define SPIPC_CPHA  2
`define SPIPC_CPOL  3
`define SPIPC_LSBF  5
`define SPIPC_TXM   6
`define SPIPC_UDM   7
`define SPIPC_OVW   8
`define SPIPC_SSEN  9
`define SPIPC_SOEN  10
`define SPIPC_LOOP  11
`define SPIPC_CONT  12

// reset values and writable mask
`define SPIPC_CTRL_RST   16'h0000
`define SPIPC_CTRL_MASK  16'h1FEF
`define SPIPC_DIV_RST    8'h00

// bus responses
`define SPIPC_OKAY    2'b00
`define SPIPC_SLVERR  2'b10

// last half period of a byte, last of the gap
`define SPIPC_LAST_HALF  4'hF
`define SPIPC_LAST_BIT   3'h7
`define SPIPC_GAP_END    4'h2

`endif

// ==== rtl/spipc_top.sv ====
// Overview of operation
// - 16-bit control register, top three bits and bit 4 reserved
// - 8-bit status register, read only
// - 8-bit divider sets master bit rate
// - 8-bit write-only transmit byte register
// - 8-bit read-only receive byte register
// - continuous mode: back-to-back bytes, select held
// - single mode: one byte, stall before next
// - loopback routes data output to input
// - slave data output driven only when enabled
// - master drives select only when enabled
// - overflow: overwrite or discard by control bit
// - underflow: resend previous byte or zeros
// - transmit-mode master: write starts, empty flags
// - receive-mode master: read starts, full flags
// - bit order: lsb or msb first
// - clock idles at the polarity bit level
// - phase selects clock pulse at bit start
// - master bit selects master or slave
// - enable bit gates the whole port
// - bit rate is core over two(div+1)
// - launch one edge, sample the other
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`include "spipc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module spipc_top (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serial clock pin
   input  wire logic        sclk_i,
   output logic             sclk_o,
   output logic             sclk_oe,
   // master-out data pin
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe,
   // master-in data pin
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe,
   // chip select pin, active low
   input  wire logic        cs_n_i,
   output logic             cs_n_o,
   output logic             cs_n_oe
);

   // software-visible state
   logic [15:0] ctrl_r;
   logic [7:0]  div_r;
   logic [7:0]  tx_r;
   logic [7:0]  prev_r;
   logic [7:0]  rx_r;
   logic        tx_full_r;
   logic        udf_r;
   logic        rx_full_r;
   logic        ovf_r;
   logic        start_req_r;

   // shift engine state
   spipc_pkg::spipc_state_t st_r;
   logic [7:0]  dcnt_r;
   logic [3:0]  h_r;
   logic        lvl_r;
   logic [7:0]  sh_r;
   logic [7:0]  rs_r;
   logic [2:0]  bc_r;
   logic        sclk_q_r;
   logic        sel_r;

   // bus state
   logic        aw_have_r;
   logic        w_have_r;
   logic [7:0]  awa_r;
   logic [31:0] wd_r;
   logic [3:0]  ws_r;

   // word-aligned address match
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction : hit

   // one shift step in the chosen bit order
   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                           input logic lsb);
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction : shift_in

   // any mapped register
   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, `SPIPC_CTRL_OFF) | hit(a, `SPIPC_STAT_OFF) |
               hit(a, `SPIPC_DIV_OFF) | hit(a, `SPIPC_TX_OFF) |
               hit(a, `SPIPC_RX_OFF);
   endfunction : mapped

   // control fields
   logic en, mst, cpha, cpol, lsbf, txm, udm, ovw, ssen, soen, loop, cont;
   assign en   = ctrl_r[`SPIPC_EN];
   assign mst  = ctrl_r[`SPIPC_MST];
   assign cpha = ctrl_r[`SPIPC_CPHA];
   assign cpol = ctrl_r[`SPIPC_CPOL];
   assign lsbf = ctrl_r[`SPIPC_LSBF];
   assign txm  = ctrl_r[`SPIPC_TXM];
   assign udm  = ctrl_r[`SPIPC_UDM];
   assign ovw  = ctrl_r[`SPIPC_OVW];
   assign ssen = ctrl_r[`SPIPC_SSEN];
   assign soen = ctrl_r[`SPIPC_SOEN];
   assign loop = ctrl_r[`SPIPC_LOOP];
   assign cont = ctrl_r[`SPIPC_CONT];

   // bus handshakes, one write and one read in flight
   logic wr_fire, rd_fire, tx_wr, rx_rd;
   assign s_axi_awready = !aw_have_r & !s_axi_bvalid;
   assign s_axi_wready  = !w_have_r & !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_have_r & w_have_r & !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign tx_wr   = wr_fire & hit(awa_r, `SPIPC_TX_OFF) & ws_r[0];
   assign rx_rd   = rd_fire & hit(s_axi_araddr, `SPIPC_RX_OFF);

   // master timing and edge decode
   logic m_act, tick, m_edge, m_last, start, load_m;
   assign m_act  = en & mst;
   assign tick   = (st_r != spipc_pkg::SPIPC_IDLE) & (dcnt_r >= div_r);
   assign m_edge = tick & (st_r == spipc_pkg::SPIPC_XFER);
   assign m_last = m_edge & (h_r == `SPIPC_LAST_HALF);
   assign start  = m_act & (st_r == spipc_pkg::SPIPC_IDLE) &
                   (txm ? tx_full_r : start_req_r);
   assign load_m = start | (m_last & cont & tx_full_r);

   // slave select and sampled clock edges
   logic s_sel, s_start, s_lead, s_trail;
   assign s_sel   = en & !mst & !cs_n_i;
   assign s_start = s_sel & !sel_r;
   assign s_lead  = s_sel & sel_r & (sclk_q_r == cpol) & (sclk_i != cpol);
   assign s_trail = s_sel & sel_r & (sclk_q_r != cpol) & (sclk_i == cpol);

   // leading edge samples unless phase moves launch to it
   logic lead, trail, samp, shft;
   assign lead  = mst ? (m_edge & !h_r[0]) : s_lead;
   assign trail = mst ? (m_edge & h_r[0]) : s_trail;
   assign samp  = cpha ? trail : lead;
   assign shft  = cpha ? lead : trail;

   // serial data path
   logic out_bit, in_bit, byte_done, load;
   logic [7:0] rs_nxt, ld_val;
   assign out_bit   = lsbf ? sh_r[0] : sh_r[7];
   assign in_bit    = loop ? out_bit : (mst ? miso_i : mosi_i);
   assign rs_nxt    = shift_in(rs_r, in_bit, lsbf);
   assign byte_done = samp & (bc_r == `SPIPC_LAST_BIT);
   assign load      = load_m | s_start | (byte_done & !mst);
   assign ld_val    = tx_full_r ? tx_r : (udm ? prev_r : 8'h00);

   // pin drivers
   assign sclk_o  = cpol ^ lvl_r;
   assign sclk_oe = m_act;
   assign mosi_o  = out_bit;
   assign mosi_oe = m_act;
   assign miso_o  = out_bit;
   assign miso_oe = en & !mst & soen & !cs_n_i;
   // select held through the last sampling edge of a byte
   assign cs_n_o  = !((st_r == spipc_pkg::SPIPC_XFER) |
                      ((st_r == spipc_pkg::SPIPC_GAP) & (h_r == 4'h0)));
   assign cs_n_oe = m_act & ssen;

   // write address and data captured in either order
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awa_r     <= 8'h00;
         wd_r      <= 32'h0000_0000;
         ws_r      <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= 1'b1;
            awa_r     <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_r <= 1'b1;
            wd_r     <= s_axi_wdata;
            ws_r     <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // write response, error for unmapped offsets
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SPIPC_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(awa_r) ? `SPIPC_OKAY : `SPIPC_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control and divider; status and receive ignore writes
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_r <= `SPIPC_CTRL_RST;
         div_r  <= `SPIPC_DIV_RST;
      end else if (wr_fire) begin
         if (hit(awa_r, `SPIPC_CTRL_OFF) & ws_r[0]) begin
            ctrl_r[7:0] <= wd_r[7:0] & 8'(`SPIPC_CTRL_MASK);
         end
         if (hit(awa_r, `SPIPC_CTRL_OFF) & ws_r[1]) begin
            ctrl_r[15:8] <= wd_r[15:8] & 8'(`SPIPC_CTRL_MASK >> 8);
         end
         if (hit(awa_r, `SPIPC_DIV_OFF) & ws_r[0]) begin
            div_r <= wd_r[7:0];
         end
      end
   end

   // read mux, reserved bits read zero
   logic [7:0] stat;
   logic [31:0] rd_val;
   assign stat = {2'b00, ovf_r, rx_full_r | ovf_r, rx_full_r, udf_r,
                  en & (!tx_full_r | udf_r), tx_full_r};
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit(s_axi_araddr, `SPIPC_CTRL_OFF)) begin
         rd_val[15:0] = ctrl_r;
      end else if (hit(s_axi_araddr, `SPIPC_STAT_OFF)) begin
         rd_val[7:0] = stat;
      end else if (hit(s_axi_araddr, `SPIPC_DIV_OFF)) begin
         rd_val[7:0] = div_r;
      end else if (hit(s_axi_araddr, `SPIPC_RX_OFF)) begin
         rd_val[7:0] = rx_r;
      end
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `SPIPC_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= mapped(s_axi_araddr) ? `SPIPC_OKAY : `SPIPC_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // transmit holding register; a new write beats the load clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_r      <= 8'h00;
         prev_r    <= 8'h00;
         tx_full_r <= 1'b0;
         udf_r     <= 1'b0;
      end else begin
         if (tx_wr) begin
            tx_r <= wd_r[7:0];
         end
         if (load & tx_full_r) begin
            prev_r <= tx_r;
         end
         if (tx_wr) begin
            tx_full_r <= 1'b1;
         end else if (load) begin
            tx_full_r <= 1'b0;
         end
         if (load & !tx_full_r) begin
            udf_r <= 1'b1;
         end else if (tx_wr) begin
            udf_r <= 1'b0;
         end
      end
   end

   // receive register; a byte landing on a read is kept
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rx_r      <= 8'h00;
         rx_full_r <= 1'b0;
         ovf_r     <= 1'b0;
      end else if (byte_done) begin
         if (!rx_full_r | rx_rd | ovw) begin
            rx_r <= rs_nxt;
         end
         rx_full_r <= 1'b1;
         if (rx_full_r & !rx_rd) begin
            ovf_r <= 1'b1;
         end else if (rx_rd) begin
            ovf_r <= 1'b0;
         end
      end else if (rx_rd) begin
         rx_full_r <= 1'b0;
         ovf_r     <= 1'b0;
      end
   end

   // a receive read arms the next master byte
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         start_req_r <= 1'b0;
      end else if (rx_rd & m_act & !txm) begin
         start_req_r <= 1'b1;
      end else if (start | !m_act) begin
         start_req_r <= 1'b0;
      end
   end

   // shifters; no launch before the first sample of a byte
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sh_r <= 8'h00;
         rs_r <= 8'h00;
         bc_r <= 3'h0;
      end else if (!en | (!mst & cs_n_i)) begin
         sh_r <= 8'h00;
         rs_r <= 8'h00;
         bc_r <= 3'h0;
      end else begin
         if (load) begin
            sh_r <= ld_val;
         end else if (shft & (bc_r != 3'h0)) begin
            sh_r <= shift_in(sh_r, 1'b0, lsbf);
         end
         if (samp) begin
            rs_r <= rs_nxt;
            bc_r <= bc_r + 3'h1;
         end
      end
   end

   // slave pin history, inputs already in this clock
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sclk_q_r <= 1'b0;
         sel_r    <= 1'b0;
      end else begin
         sclk_q_r <= sclk_i;
         sel_r    <= s_sel;
      end
   end

   // master sequencer: sixteen half periods, then gap or next byte
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_r   <= spipc_pkg::SPIPC_IDLE;
         dcnt_r <= 8'h00;
         h_r    <= 4'h0;
         lvl_r  <= 1'b0;
      end else if (!m_act) begin
         st_r   <= spipc_pkg::SPIPC_IDLE;
         dcnt_r <= 8'h00;
         h_r    <= 4'h0;
         lvl_r  <= 1'b0;
      end else begin
         unique case (st_r)
            spipc_pkg::SPIPC_IDLE: begin
               dcnt_r <= 8'h00;
               h_r    <= 4'h0;
               if (start) begin
                  st_r <= spipc_pkg::SPIPC_XFER;
               end
            end
            spipc_pkg::SPIPC_XFER: begin
               if (tick) begin
                  dcnt_r <= 8'h00;
                  h_r    <= h_r + 4'h1;
                  lvl_r  <= ~lvl_r;
                  if (m_last & !(cont & tx_full_r)) begin
                     st_r <= spipc_pkg::SPIPC_GAP;
                  end
               end else begin
                  dcnt_r <= dcnt_r + 8'h01;
               end
            end
            spipc_pkg::SPIPC_GAP: begin
               if (tick) begin
                  dcnt_r <= 8'h00;
                  h_r    <= h_r + 4'h1;
                  if (h_r == `SPIPC_GAP_END) begin
                     st_r <= spipc_pkg::SPIPC_IDLE;
                  end
               end else begin
                  dcnt_r <= dcnt_r + 8'h01;
               end
            end
         endcase
      end
   end

   default clocking dc @(posedge mclk); endclocking
   default disable iff (reset);

   div_rate_a: assert property ((m_edge && div_r != 8'h00) |=> (!m_edge && dcnt_r == 8'h00))
      else $error("half period restart wrong");
   cont_hold_a: assert property ((m_last & cont & tx_full_r & m_act) |=>
      (!cs_n_o && h_r == 4'h0))
      else $error("continuous byte dropped select");
   gap_cs_a: assert property ((m_last & !(cont & tx_full_r) & m_act) |=>
      (!cs_n_o && st_r == spipc_pkg::SPIPC_GAP))
      else $error("select dropped on last edge");
   gap_high_a: assert property ((m_act && st_r == spipc_pkg::SPIPC_GAP && h_r != 4'h0) |-> cs_n_o)
      else $error("no gap after single byte");
   loop_path_a: assert property (loop |-> (in_bit == out_bit))
      else $error("loopback path broken");
   slave_oe_a: assert property (miso_oe |-> (soen && !mst && en))
      else $error("slave output driven while disabled");
   cs_drive_a: assert property (cs_n_oe |-> (mst && ssen && en))
      else $error("select driven outside master enable");
   ovf_keep_a: assert property ((byte_done & rx_full_r & !ovw & !rx_rd)
      |=> ($stable(rx_r) && ovf_r))
      else $error("overflow did not discard");
   udf_zero_a: assert property ((load & !tx_full_r & !udm) |=>
      (sh_r == 8'h00 && udf_r))
      else $error("underflow did not send zeros");
   idle_pol_a: assert property ((m_act && st_r != spipc_pkg::SPIPC_XFER)
      |-> (sclk_o == cpol))
      else $error("clock not at idle level");
   tx_start_a: assert property ((start & txm) |=>
      (st_r == spipc_pkg::SPIPC_XFER && !cs_n_o))
      else $error("transmit write did not start");
   rx_full_a: assert property (byte_done |=> rx_full_r)
      else $error("receive full not flagged");
   off_idle_a: assert property (!en |-> (!sclk_oe && !cs_n_oe && !miso_oe) ##1
      (st_r == spipc_pkg::SPIPC_IDLE))
      else $error("port active while disabled");

endmodule : spipc_top
`default_nettype wire

// ==== sim/spipc_slave_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module spipc_slave_model (
   // link pins
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       cs_n,
   output logic            miso,
   // mode and data
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       lsbf,
   input  wire logic [7:0] tx_byte,
   output logic [7:0]      rx_byte
);
   logic [2:0] nsamp;
   logic [2:0] oidx;
   logic       cur;
   logic       idle_v = 1'b0;

   // a new frame restarts the bit count
   always @(negedge cs_n) begin
      nsamp = 3'h0;
      oidx  = 3'h0;
   end

   // sample on one edge, launch on the other
   always @(sclk) begin
      if (!cs_n && ((sclk != cpol) != cpha)) begin
         rx_byte[lsbf ? nsamp : 3'h7 - nsamp] = mosi;
         nsamp = nsamp + 3'h1;
      end else if (!cs_n) begin
         oidx = nsamp;
      end
   end

   // released line shows the inverse of its last bit, never a held value
   assign cur = tx_byte[lsbf ? oidx : 3'h7 - oidx];
   always @(posedge cs_n) idle_v = ~cur;
   assign miso = cs_n ? idle_v : cur;
endmodule : spipc_slave_model
`default_nettype wire

// ==== sim/testbench.sv ====
`include "spipc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module testbench;
   localparam logic [7:0] o_ct = `SPIPC_CTRL_OFF;
   localparam logic [7:0] o_st = `SPIPC_STAT_OFF;
   localparam logic [7:0] o_dv = `SPIPC_DIV_OFF;
   localparam logic [7:0] o_tx = `SPIPC_TX_OFF;
   localparam logic [7:0] o_rx = `SPIPC_RX_OFF;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   logic        sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, cs_n_o, cs_n_oe, s_miso;
   logic        m_sclk = 1'b0;
   logic        m_mosi = 1'b0;
   logic        m_cs_n = 1'b1;
   logic        m_cpol = 1'b0;
   logic        m_cpha = 1'b0;
   logic        m_lsbf = 1'b0;
   logic [7:0]  s_tx = 8'h00;
   logic [7:0]  s_rx, mi;
   time         per = 0, t_sc = 0, t_rise = 0, gap = 0;
   int          cs_rise = 0, i, n_mismatch = 0, checks_done = 0;

   // pin levels from every driver; the bench drives select, idling high, whenever the port does not
   wire sclk = sclk_oe ? sclk_o : m_sclk;
   wire mosi = mosi_oe ? mosi_o : m_mosi;
   wire miso = miso_oe ? miso_o : s_miso;
   wire cs_n = cs_n_oe ? cs_n_o : m_cs_n;

   spipc_top spipc_top_inst (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .sclk_i(sclk), .sclk_o, .sclk_oe,
      .mosi_i(mosi), .mosi_o, .mosi_oe, .miso_i(miso), .miso_o, .miso_oe, .cs_n_i(cs_n),
      .cs_n_o, .cs_n_oe);

   spipc_slave_model spipc_slave_model_inst (.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(s_miso),
      .cpol(m_cpol), .cpha(m_cpha), .lsbf(m_lsbf), .tx_byte(s_tx), .rx_byte(s_rx));

   initial forever #4 mclk = ~mclk;

   // serial clock period and select framing monitors
   always @(posedge sclk_o) begin
      per = $time - t_sc;
      t_sc = $time;
   end
   always @(posedge cs_n_o) begin
      cs_rise++;
      t_rise = $time;
   end
   always @(negedge cs_n_o) gap = $time - t_rise;

   task automatic finish_test();
      if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test

   // ready and response are kept up, so only valids are toggled
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      resp = s_axi_bresp;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      resp = s_axi_rresp;
   endtask : axr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      axr(a, rd);
      `CHK(rd, e)
   endtask : rdchk

   // poll a status bit; only the watchdog ends a hang
   task automatic wait_st(input int b, input logic v);
      forever begin
         axr(o_st, rd);
         if (rd[b] === v) break;
      end
   endtask : wait_st

   // bench as external master, mode 0, msb first
   task automatic sbyte(input logic [7:0] mo, output logic [7:0] q, input logic oe);
      int k;
      m_cs_n <= 1'b0;
      for (k = 7; k >= 0; k--) begin
         m_mosi <= mo[k];
         repeat (4) @(posedge mclk);
         m_sclk <= 1'b1;
         q[k] = miso;
         if (k == 0) `CHK(miso_oe, oe)
         repeat (4) @(posedge mclk);
         m_sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      m_cs_n <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask : sbyte

   initial begin
      repeat (60000) @(posedge mclk);
      n_mismatch++;
      finish_test();
   end

   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rdchk(o_ct, 32'h0);
      rdchk(o_dv, 32'h0);
      axw(o_st, 32'hFF);
      `CHK(resp, `SPIPC_OKAY)
      rdchk(o_st, 32'h0);
      axw(o_ct, 32'hFFFF);
      rdchk(o_ct, 32'h1FEF);
      axw(o_ct, 32'h0);
      rdchk(o_tx, 32'h0);
      axw(o_dv, 32'hFF);
      rdchk(o_dv, 32'hFF);
      rdchk(8'h14, 32'h0);
      `CHK(resp, `SPIPC_SLVERR)
      // every clock mode and bit order, three divider values
      for (i = 0; i < 8; i++) begin
         {m_lsbf, m_cpol, m_cpha} = i[2:0];
         s_tx = 8'(8'h4D + i);
         axw(o_dv, i % 3);
         axw(o_ct, 32'h0243 | (i[2] << 5) | (i[1] << 3) | (i[0] << 2));
         `CHK(sclk_o, m_cpol)
         axw(o_tx, 8'h96 ^ i);
         wait_st(3, 1'b1);
         rdchk(o_rx, s_tx);
         `CHK(s_rx, 8'(8'h96 ^ i))
         `CHK(per, 16 * (i % 3 + 1))
         axr(o_st, rd);
         `CHK(rd[1:0], 2'b10)
         `CHK(cs_n_oe, 1'b1)
      end
      // receive-started transfer, partner back in mode 0 msb first
      {m_lsbf, m_cpol, m_cpha} = 3'b000;
      axw(o_ct, 32'h0203);
      s_tx = 8'h5A;
      axr(o_rx, rd);
      wait_st(3, 1'b1);
      rdchk(o_rx, 32'h5A);
      wait_st(3, 1'b1);
      axr(o_st, rd);
      `CHK(rd[4], 1'b1)
      axw(o_ct, 32'h0A43);
      axr(o_rx, rd);
      s_tx = 8'h00;
      axw(o_tx, 32'hC3);
      wait_st(3, 1'b1);
      rdchk(o_rx, 32'hC3);
      // overflow discard, then overwrite
      for (i = 0; i < 2; i++) begin
         axw(o_ct, 32'h0243 | (i << 8));
         s_tx = 8'h11;
         axw(o_tx, 32'h01);
         wait_st(3, 1'b1);
         s_tx = 8'h22;
         axw(o_tx, 32'h02);
         wait_st(5, 1'b1);
         rdchk(o_rx, i ? 8'h22 : 8'h11);
      end
      // two queued bytes, single then continuous
      axw(o_dv, 32'h3);
      for (i = 0; i < 2; i++) begin
         axw(o_ct, 32'h0243 | (i << 12));
         cs_rise = 0;
         axw(o_tx, 32'h33);
         axw(o_tx, 32'h44);
         wait_st(0, 1'b0);
         while (cs_n_o !== 1'b1) @(posedge mclk);
         `CHK(cs_rise, 2 - i)
         if (i == 0) `CHK(gap >= 64, 1'b1)
         `CHK(s_rx, 8'h44)
         axr(o_rx, rd);
      end
      axw(o_ct, 32'h0043);
      `CHK(cs_n_oe, 1'b0)
      axw(o_ct, 32'h0201);
      `CHK(sclk_oe, 1'b0)
      axw(o_ct, 32'h0242);
      `CHK(mosi_oe, 1'b0)
      // slave mode: data out, underflow resend and zeros, output off
      axw(o_ct, 32'h0401);
      axw(o_tx, 32'h81);
      sbyte(8'h6B, mi, 1'b1);
      `CHK(mi, 8'h81)
      wait_st(3, 1'b1);
      rdchk(o_rx, 32'h6B);
      axw(o_ct, 32'h0481);
      sbyte(8'h00, mi, 1'b1);
      `CHK(mi, 8'h81)
      axw(o_ct, 32'h0401);
      sbyte(8'h00, mi, 1'b1);
      `CHK(mi, 8'h00)
      axw(o_ct, 32'h0001);
      sbyte(8'h00, mi, 1'b0);
      finish_test();
   end
endmodule : testbench
`default_nettype wire
